// ---- rtl/eprom_ctl_params.svh ----
// Timing and geometry constants for the EPROM program/verify controller.
`ifndef EPROM_CTL_PARAMS_SVH
`define EPROM_CTL_PARAMS_SVH
`define CLK_PERIOD_NS 100
`define ADDR_W 12
`define DATA_W 8
`define WORDS 4096
`define ERASED_BYTE 8'hFF
`define PGM_PULSE_NOM_MS 50
`define PGM_PULSE_MAX_MS 55
`define PGM_PULSE_CYC ((`PGM_PULSE_NOM_MS * 1000000) / `CLK_PERIOD_NS)
`define PGM_PULSE_MAX_CYC ((`PGM_PULSE_MAX_MS * 1000000) / `CLK_PERIOD_NS)
`define SETUP_US 2
`define SETUP_CYC ((`SETUP_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACCESS_NS 450
`define ACCESS_CYC ((`ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OE_LATE_NS 330
`define OE_LATE_CYC (`OE_LATE_NS / `CLK_PERIOD_NS)
`define VERIFY_DV_NS 450
`define VERIFY_DV_CYC ((`VERIFY_DV_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ---- rtl/eprom_ctl_pkg.sv ----
// Types shared by the EPROM program/verify controller.
package eprom_ctl_pkg;
  typedef enum logic [1:0] {
    CMD_READ,
    CMD_PROGRAM,
    CMD_VERIFY
  } cmd_e;
  typedef struct packed {
    cmd_e cmd;
    logic [11:0] addr;
    logic [7:0] data;
    logic [1:0] dev;
  } req_s;
  typedef struct packed {
    logic [7:0] data;
    logic mismatch;
  } rsp_s;
endpackage : eprom_ctl_pkg

// ---- rtl/eprom_pin_timer.sv ----
// Down counter that times each phase of a pin sequence.
`timescale 1ns/1ps
module eprom_pin_timer #(
  parameter int W = 20
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [W-1:0] count,
  output logic done
);
  logic [W-1:0] remain;
  // Load sets a fresh count; done rises one cycle after it reaches zero.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      remain <= '0;
    end else if (load) begin
      remain <= count;
    end else if (remain != '0) begin
      remain <= remain - 1'b1;
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      done <= 1'b0;
    end else begin
      done <= !load && (remain == '0);
    end
  end
endmodule : eprom_pin_timer

// ---- rtl/eprom_prog_ctl.sv ----
// Host-side controller that reads, programs and verifies an EPROM array.
// Functional notes
// R01: Chip select decoded per device; output enable common, driven as read strobe.
// R02: Device drives data only when selected and read; we float while reading.
// R03: Shared inputs across devices; only the addressed device gets a program pulse.
// R04: Strobes of devices not being programmed stay high throughout programming.
// R05: Every programmed location is read back and compared with intended data.
// R06: Verify holds both enables low; data sampled after valid delay.
// R07: Output enable falls no later than 330 ns after chip select.
// R08: Programming mode signalled by programming voltage request on shared pin.
// R09: Exactly one high pulse, 50 ms nominal, never above 55 ms; the strobe is driven low for the pulse.
// R10: Erased bytes read FF; programming only clears bits to zero.
// R11: Chip select high places device in standby with outputs floating.
// R12: Programming voltage presence is a separate mode output bit.
`timescale 1ns/1ps
`include "eprom_ctl_params.svh"
module eprom_prog_ctl
  import eprom_ctl_pkg::*;
#(
  parameter int DEVS = 4,
  parameter int PULSE_CYC = `PGM_PULSE_CYC,
  parameter int PULSE_MAX_CYC = `PGM_PULSE_MAX_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire req_s req,
  output logic req_ready,
  output logic rsp_valid,
  output rsp_s rsp,
  output logic rsp_error,
  output logic [DEVS-1:0] select_program_strobe,
  output logic output_enable_n,
  output logic vpp_mode,
  output logic [`ADDR_W-1:0] addr,
  output logic [`DATA_W-1:0] data_out,
  output logic data_oe_n,
  input wire logic [`DATA_W-1:0] data_in
);
  typedef enum {
    ST_IDLE,
    ST_SETUP,
    ST_PULSE,
    ST_HOLD,
    ST_SELECT,
    ST_ACCESS,
    ST_DONE
  } state_e;

  localparam int TW = 20;

  state_e state;
  state_e next_state;
  req_s cur;
  logic tmr_load;
  logic [TW-1:0] tmr_count;
  logic tmr_done;
  logic [DEVS-1:0] dev_bit;
  logic [TW-1:0] pulse_len;

  // Timer phases follow on from each other, so one counter serves all.
  eprom_pin_timer #(.W(TW)) u_timer (
    .core_clk(core_clk),
    .rst(rst),
    .load(tmr_load),
    .count(tmr_count),
    .done(tmr_done)
  );

  // One-hot decode of the device index for the chip select pins.
  function automatic logic [DEVS-1:0] dev_onehot(input logic [1:0] idx);
    logic [DEVS-1:0] v;
    v = '0;
    v[idx] = 1'b1;
    return v;
  endfunction : dev_onehot

  // Clamp the pulse so a mis-set parameter can never overstress a cell.
  // A timed phase lasts its count plus two cycles, so the clamp keeps that margin.
  // R09: pulse width bound
  assign pulse_len = TW'((PULSE_CYC > PULSE_MAX_CYC - 2) ? PULSE_MAX_CYC - 2 : PULSE_CYC);
  assign dev_bit = dev_onehot(cur.dev);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer.

  // Next state and timer reload; phases advance only when the timer expires.
  always_comb begin
    next_state = state;
    tmr_load = 1'b0;
    tmr_count = '0;
    case (state)
      ST_IDLE: begin
        if (req_valid) begin
          next_state = (req.cmd == CMD_PROGRAM) ? ST_SETUP : ST_SELECT;
          tmr_load = 1'b1;
          tmr_count = TW'(`SETUP_CYC);
        end
      end
      ST_SETUP: begin
        if (tmr_done) begin
          next_state = ST_PULSE;
          tmr_load = 1'b1;
          tmr_count = pulse_len;
        end
      end
      ST_PULSE: begin
        if (tmr_done) begin
          next_state = ST_HOLD;
          tmr_load = 1'b1;
          tmr_count = TW'(`SETUP_CYC);
        end
      end
      ST_HOLD: begin
        if (tmr_done) begin
          next_state = ST_SELECT;
          tmr_load = 1'b1;
          tmr_count = TW'(`SETUP_CYC);
        end
      end
      ST_SELECT: begin
        if (tmr_done) begin
          next_state = ST_ACCESS;
          tmr_load = 1'b1;
          tmr_count = TW'(`VERIFY_DV_CYC);
        end
      end
      ST_ACCESS: begin
        if (tmr_done) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Capture the request once; strobe decode and answer use this copy, while addr and data_out register req directly.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cur <= '0;
    end else if (state == ST_IDLE && req_valid) begin
      cur <= req;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      req_ready <= 1'b0;
    end else begin
      req_ready <= (next_state == ST_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive, all registered; strobes and enables decode the next state.

  // R01: decoded chip select
  // R03: only the addressed strobe pulses
  // R04: other strobes held high
  // R11: idle leaves every device in standby
  // R06: verify holds select low
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      select_program_strobe <= '1;
    end else begin
      case (next_state)
        ST_PULSE: select_program_strobe <= ~dev_bit;
        ST_SELECT, ST_ACCESS: select_program_strobe <= ~dev_bit;
        default: select_program_strobe <= '1;
      endcase
    end
  end

  // Output enable falls together with select, well inside the 330 ns allowance.
  // R07: early output enable
  // R06: verify holds output enable low
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      output_enable_n <= 1'b1;
    end else begin
      output_enable_n <= !(next_state == ST_SELECT || next_state == ST_ACCESS);
    end
  end

  // R08: programming voltage request
  // R12: separate mode bit
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      vpp_mode <= 1'b0;
    end else begin
      vpp_mode <= (next_state == ST_SETUP || next_state == ST_PULSE || next_state == ST_HOLD);
    end
  end

  // The data bus is ours only around the program pulse, avoiding contention.
  // R02: host floats during reads
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      data_oe_n <= 1'b1;
      data_out <= `ERASED_BYTE;
      addr <= '0;
    end else begin
      data_oe_n <= !(next_state == ST_SETUP || next_state == ST_PULSE
                     || next_state == ST_HOLD);
      if (state == ST_IDLE && req_valid) begin
        addr <= req.addr;
        data_out <= req.data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Answer.

  // R05: compare readback after programming
  // R10: a bit cannot be set back to one
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp <= '0;
      rsp_error <= 1'b0;
    end else begin
      rsp_valid <= (state == ST_ACCESS && tmr_done);
      if (state == ST_ACCESS && tmr_done) begin
        rsp.data <= data_in;
        rsp.mismatch <= (cur.cmd != CMD_READ) && (data_in != cur.data);
        rsp_error <= (cur.cmd == CMD_PROGRAM) && |(cur.data & ~data_in);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  logic [TW-1:0] low_cnt;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      low_cnt <= '0;
    end else if (vpp_mode && select_program_strobe != '1) begin
      low_cnt <= low_cnt + 1'b1;
    end else begin
      low_cnt <= '0;
    end
  end

  a_pulse_width_max: assert property (@(posedge core_clk) disable iff (rst) // R09
    low_cnt <= TW'(PULSE_MAX_CYC)) else $error("program pulse too long");
  a_strobe_one_device: assert property (@(posedge core_clk) disable iff (rst) // R04
    $onehot0(~select_program_strobe)) else $error("more than one device selected");
  a_verify_enables: assert property (@(posedge core_clk) disable iff (rst) // R06
    rsp_valid |-> $past(!output_enable_n && select_program_strobe != '1))
    else $error("verify sampled without both enables low");
  a_oe_with_select: assert property (@(posedge core_clk) disable iff (rst) // R07
    $fell(&select_program_strobe) && !vpp_mode |-> !output_enable_n)
    else $error("output enable late after select");
  a_vpp_no_read: assert property (@(posedge core_clk) disable iff (rst) // R08
    vpp_mode |-> output_enable_n) else $error("read enable during programming");
  a_float_on_read: assert property (@(posedge core_clk) disable iff (rst) // R02
    !output_enable_n |-> data_oe_n) else $error("host drives bus during read");
  a_program_verifies: assert property (@(posedge core_clk) disable iff (rst) // R05
    $fell(vpp_mode) |-> ##[1:40] !output_enable_n) else $error("no verify after program");
  a_idle_standby: assert property (@(posedge core_clk) disable iff (rst) // R11
    state == ST_IDLE |-> &select_program_strobe) else $error("device selected while idle");
  a_setup_before_pulse: assert property (@(posedge core_clk) disable iff (rst) // R03
    $rose(vpp_mode) |-> (&select_program_strobe) [*8]) else $error("pulse without setup");
endmodule : eprom_prog_ctl

// ---- test/eprom_dev_model.sv ----
// Behavioural model of one 4096 x 8 erasable memory on the controller's pins.
`timescale 1ns/1ps
`include "eprom_ctl_params.svh"
module eprom_dev_model #(
  parameter int MAX_PW_NS = 5500
) (
  input wire logic strobe_n,
  input wire logic oe_n,
  input wire logic vpp,
  input wire logic [`ADDR_W-1:0] addr,
  input wire logic [`DATA_W-1:0] din,
  output logic [`DATA_W-1:0] dout,
  output logic drv
);
  logic [`DATA_W-1:0] mem [`WORDS];
  logic valid;
  realtime t_fall;
  //////////////////////////////////////////////////////////////////////////////
  // erased contents
  // Every word starts erased, with all bits at one.
  initial begin
    foreach (mem[i]) mem[i] = `ERASED_BYTE;
    valid = 1'b0;
    t_fall = 0;
  end
  // output gating
  // Pins float in standby or programming; before access time the word is garbled.
  assign drv = !strobe_n && !oe_n && !vpp;
  assign dout = valid ? mem[addr] : ~mem[addr];
  // Data only becomes valid once the access time has run after select.
  always @(negedge strobe_n) begin
    t_fall = $realtime;
    valid = 1'b0;
    #(`ACCESS_NS) valid = !strobe_n;
  end
  // program pulse
  // A pulse with programming voltage clears bits; an overlong pulse stores nothing.
  always @(posedge strobe_n) begin
    valid = 1'b0;
    if (vpp && ($realtime - t_fall) <= MAX_PW_NS) begin
      mem[addr] = mem[addr] & din;
    end
  end
endmodule : eprom_dev_model

// ---- test/eprom_prog_ctl_tb.sv ----
// Self-checking bench for the program/verify controller with four device models.
`timescale 1ns/1ps
`include "eprom_ctl_params.svh"
module eprom_prog_ctl_tb;
  import eprom_ctl_pkg::*;
  localparam int PMAX = 55;
  logic core_clk, rst, req_valid, req_ready, rsp_valid, rsp_error;
  logic output_enable_n, vpp_mode, data_oe_n;
  req_s req;
  rsp_s rsp;
  logic [3:0] select_program_strobe;
  wire [3:0] drv;
  logic [11:0] addr;
  logic [7:0] data_out, data_in, last, wr_bus;
  wire [7:0] dq [4];
  int n_fail, checked, plen, pulses, late;
  //////////////////////////////////////////////////////////////////////////////
  // Short pulse counts keep the run brief; the models judge width in time.
  eprom_prog_ctl #(.DEVS(4), .PULSE_CYC(50), .PULSE_MAX_CYC(PMAX)) u_eprom_prog_ctl (
    .core_clk(core_clk), .rst(rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp), .rsp_error(rsp_error),
    .select_program_strobe(select_program_strobe), .output_enable_n(output_enable_n),
    .vpp_mode(vpp_mode), .addr(addr), .data_out(data_out), .data_oe_n(data_oe_n),
    .data_in(data_in));
  for (genvar g = 0; g < 4; g++) begin : g_dev
    eprom_dev_model u_dev (.strobe_n(select_program_strobe[g]), .oe_n(output_enable_n),
      .vpp(vpp_mode), .addr(addr), .din(wr_bus), .dout(dq[g]), .drv(drv[g]));
  end
  // Undriven lines show the inverse of their last value, never a lucky match.
  assign wr_bus = (data_oe_n === 1'b0) ? data_out : ~data_out;
  always_comb begin
    data_in = ~last;
    for (int i = 0; i < 4; i++) if (drv[i]) data_in = dq[i];
  end
  always @(posedge core_clk) if (|drv) last <= data_in;
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [8:0] seen, input logic [8:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic conclude;
    if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  // One request: wait for idle, present it for one edge, then await the answer.
  task automatic xfer(input cmd_e c, input logic [11:0] a, input logic [7:0] d,
                      input logic [1:0] v);
    int n;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 200);
    check({8'h00, req_ready}, 9'h001, "never ready");
    @(posedge core_clk);
    req_valid <= 1'b1;
    req <= '{cmd: c, addr: a, data: d, dev: v};
    @(posedge core_clk);
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 2000);
    check({8'h00, rsp_valid}, 9'h001, "no answer");
  endtask : xfer
  //////////////////////////////////////////////////////////////////////////////
  // pin monitor
  // One select at a time, read strobe soon after select, pulse width bounded.
  always @(posedge core_clk) begin
    if (!rst) begin
      check({8'h00, $countones(~select_program_strobe) > 1}, 9'h000, "two selected");
      if (vpp_mode === 1'b1 && select_program_strobe !== 4'hF) plen++;
      else if (plen > 0) begin
        pulses++;
        check({8'h00, plen > PMAX}, 9'h000, "pulse too long");
        plen = 0;
      end
      if (vpp_mode === 1'b0 && select_program_strobe !== 4'hF && output_enable_n === 1'b1)
        late++;
      else late = 0;
      check({8'h00, late > `OE_LATE_CYC}, 9'h000, "read strobe late");
    end
  end
  task automatic t_read_erased;
    for (int i = 0; i < 4; i++) begin
      xfer(CMD_READ, 12'h000, 8'h00, 2'(i));
      check({1'b0, rsp.data}, 9'h0FF, "erased read");
    end
  endtask : t_read_erased
  task automatic t_program;
    pulses = 0;
    xfer(CMD_PROGRAM, 12'h123, 8'hA5, 2'd1);
    check(rsp, {8'hA5, 1'b0}, "program readback");
    check({8'h00, rsp_error}, 9'h000, "program error");
    check(9'(pulses), 9'h001, "pulse count");
  endtask : t_program
  task automatic t_inhibit;
    for (int i = 0; i < 4; i += 2) begin
      xfer(CMD_READ, 12'h123, 8'h00, 2'(i + 1 - (i >> 1)));
      check({1'b0, rsp.data}, i == 0 ? 9'h0A5 : 9'h0FF, "neighbour word");
    end
    xfer(CMD_READ, 12'h123, 8'h00, 2'd3);
    check({1'b0, rsp.data}, 9'h0FF, "inhibited device");
  endtask : t_inhibit
  task automatic t_overprogram;
    xfer(CMD_PROGRAM, 12'h123, 8'h5A, 2'd1);
    check(rsp, {8'h00, 1'b1}, "bits only clear");
    check({8'h00, rsp_error}, 9'h001, "cleared bit flagged");
  endtask : t_overprogram
  task automatic t_verify;
    xfer(CMD_VERIFY, 12'h123, 8'h00, 2'd1);
    check(rsp, {8'h00, 1'b0}, "verify match");
    xfer(CMD_VERIFY, 12'h123, 8'hA5, 2'd1);
    check(rsp, {8'h00, 1'b1}, "verify mismatch");
  endtask : t_verify
  task automatic t_top_word;
    xfer(CMD_PROGRAM, 12'hFFF, 8'h3C, 2'd3);
    check(rsp, {8'h3C, 1'b0}, "top word program");
    xfer(CMD_READ, 12'hFFF, 8'h00, 2'd2);
    check({1'b0, rsp.data}, 9'h0FF, "top word other device");
  endtask : t_top_word
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    last = 8'h00;
    n_fail = 0;
    checked = 0;
    plen = 0;
    pulses = 0;
    late = 0;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    t_read_erased();
    t_program();
    t_inhibit();
    t_overprogram();
    t_verify();
    t_top_word();
    conclude();
  end
  // The whole run needs under a thousand cycles; this leaves ample margin.
  initial begin
    #2000000;
    n_fail++;
    conclude();
  end
endmodule : eprom_prog_ctl_tb
